// ===== hdl/periodic_timer_array.sv
// Top of the eleven-timer periodic array
//
// Summary of operation
// - The array holds eleven independent timers: one wake-up tick, four general, four DMA and two converter timers.
// - Every timer is a 24-bit down-counter.
// - When a timer's count is zero it can raise its trigger toward its consumer.
// - After zero a timer reloads its start value and keeps counting on its own, giving periodic operation.
// - The present count of every timer can be read at any moment, even while counting.
// - The wake-up tick timer counts from its own separate clock so its expiry can wake the system.
// - Every timer expiry serves as an interrupt request; only the four DMA timers' expiries also serve as DMA transfer requests.
// - Each converter timer counts at the system rate and pulses its own converter trigger line at zero.
// - The general and DMA timers can count from either the oscillator clock or the PLL system clock.
`timescale 1ns/1ps
module periodic_timer_array #(
    parameter int WIDTH = pta_pkg::COUNT_WIDTH
) (
    input  wire logic                                 mclk,
    input  wire logic                                 reset_n,
    input  wire logic                                 wakeClk,
    input  wire logic                                 oscClk,
    input  wire logic                                 srcSelect,
    input  wire logic [pta_pkg::NUM_TIMERS-1:0][WIDTH-1:0] startValue,
    input  wire logic [pta_pkg::NUM_TIMERS-1:0]       timerEnable,
    input  wire logic [pta_pkg::NUM_TIMERS-1:0]       trigEnable,
    output logic      [pta_pkg::NUM_TIMERS-1:0][WIDTH-1:0] countValue,
    output logic      [pta_pkg::NUM_TIMERS-1:0]       irqRequest,
    output logic      [pta_pkg::NUM_DMA-1:0]          dmaRequest,
    output logic                                      wakeupTick,
    output logic                                      convTriggerZero,
    output logic                                      convTriggerOne
);
    localparam int N = pta_pkg::NUM_TIMERS;
    localparam int S = pta_pkg::SYNC_STAGES;

    // Role of each slot in the array
    typedef enum logic [1:0] {
        PTA_ROLE_WAKE = 2'b00,
        PTA_ROLE_GP   = 2'b01,
        PTA_ROLE_DMA  = 2'b10,
        PTA_ROLE_CONV = 2'b11
    } pta_role_t;

    logic [S-1:0]                    wakeSync_q;
    logic [S-1:0]                    oscSync_q;
    logic [S-1:0]                    selSync_q;
    logic                            wakeLast_q;
    logic                            oscLast_q;
    logic                            wakeEdge;
    logic                            oscEdge;
    logic                            sysTick;
    logic [N-1:0]                    tickVec;
    logic [N-1:0]                    expireVec;

    // Refuse layouts the routing below cannot serve
    generate
        if (WIDTH < 2) begin : gBadWidth
            $error("periodic_timer_array: WIDTH must be at least 2");
        end

        if (N != 11) begin : gBadCount
            $error("periodic_timer_array: the array must hold eleven timers");
        end

        if (S < 2) begin : gBadSync
            $error("periodic_timer_array: at least two synchroniser stages needed");
        end

        if (pta_pkg::IDX_WAKE != 0) begin : gBadWake
            $error("periodic_timer_array: wake timer must sit in slot zero");
        end

        if (pta_pkg::IDX_GP_FIRST != pta_pkg::IDX_WAKE + 1) begin : gBadGp
            $error("periodic_timer_array: general timers must follow the wake timer");
        end

        if (pta_pkg::NUM_DMA != 4) begin : gBadDmaCount
            $error("periodic_timer_array: four DMA timers expected");
        end

        if (pta_pkg::IDX_DMA_FIRST + pta_pkg::NUM_DMA != pta_pkg::IDX_CONV_ZERO) begin : gBadDma
            $error("periodic_timer_array: DMA timers must end just before the converter timers");
        end

        if (pta_pkg::IDX_CONV_ONE != N - 1) begin : gBadConv
            $error("periodic_timer_array: second converter timer must be the last slot");
        end
    endgenerate

    // Slot index to role
    function automatic pta_role_t pta_role_of(input int idx);
        if (idx == pta_pkg::IDX_WAKE) begin
            pta_role_of = PTA_ROLE_WAKE;
        end else if (idx >= pta_pkg::IDX_CONV_ZERO) begin
            pta_role_of = PTA_ROLE_CONV;
        end else if (idx >= pta_pkg::IDX_DMA_FIRST) begin
            pta_role_of = PTA_ROLE_DMA;
        end else begin
            pta_role_of = PTA_ROLE_GP;
        end
    endfunction : pta_role_of

    // Rising edge of a synchronised level
    function automatic logic pta_rise(input logic cur, input logic last);
        pta_rise = cur && !last;
    endfunction : pta_rise

    function automatic pta_pkg::pta_src_t pta_src_sel();
        pta_src_sel = pta_pkg::pta_src_t'(selSync_q[S-1]);
    endfunction : pta_src_sel

    // Wake clock synchroniser
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wakeSync_q <= '0;
        end else begin
            wakeSync_q <= {wakeSync_q[S-2:0], wakeClk};
        end
    end

    // Oscillator clock synchroniser
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscSync_q <= '0;
        end else begin
            oscSync_q <= {oscSync_q[S-2:0], oscClk};
        end
    end

    // Source select synchroniser
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            selSync_q <= '0;
        end else begin
            selSync_q <= {selSync_q[S-2:0], srcSelect};
        end
    end

    // Last wake level; reset matches the idle pin so no false edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wakeLast_q <= 1'b0;
        end else begin
            wakeLast_q <= wakeSync_q[S-1];
        end
    end

    // Last oscillator level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscLast_q <= 1'b0;
        end else begin
            oscLast_q <= oscSync_q[S-1];
        end
    end

    assign wakeEdge = pta_rise(wakeSync_q[S-1], wakeLast_q);
    assign oscEdge  = pta_rise(oscSync_q[S-1], oscLast_q);

    // Counting rate: every system clock or each oscillator rising edge
    assign sysTick = (pta_src_sel() == pta_pkg::PTA_SRC_OSC) ? oscEdge : 1'b1;

    // Per-slot tick by role
    always_comb begin
        tickVec = '0;
        for (int i = 0; i < N; i++) begin
            case (pta_role_of(i))
                PTA_ROLE_WAKE: tickVec[i] = wakeEdge;
                PTA_ROLE_CONV: tickVec[i] = 1'b1;
                default:       tickVec[i] = sysTick;
            endcase
        end
    end

    // Eleven timers, each with its own bundle
    pta_timer_if #(.WIDTH(WIDTH)) tIf[N] ();

    generate
        for (genvar i = 0; i < N; i++) begin : gTimer
            assign tIf[i].startValue = startValue[i];
            assign tIf[i].enable     = timerEnable[i];
            assign tIf[i].trigEnable = trigEnable[i];
            assign tIf[i].tick       = tickVec[i];
            assign countValue[i] = tIf[i].count;
            assign expireVec[i]  = tIf[i].expire;

            pta_timer #(.WIDTH(WIDTH)) uTimer (
                .mclk    (mclk),
                .reset_n (reset_n),
                .bus     (tIf[i])
            );
        end
    endgenerate

    // Expiry routing to consumers
    assign irqRequest      = expireVec;
    assign dmaRequest      = expireVec[pta_pkg::IDX_DMA_FIRST +: pta_pkg::NUM_DMA];
    assign wakeupTick      = expireVec[pta_pkg::IDX_WAKE];
    assign convTriggerZero = expireVec[pta_pkg::IDX_CONV_ZERO];
    assign convTriggerOne  = expireVec[pta_pkg::IDX_CONV_ONE];
endmodule : periodic_timer_array

// ===== hdl/pta_pkg.sv
// Shared constants for the periodic timer array
package pta_pkg;
    localparam int          NUM_TIMERS   = 11;
    localparam int          COUNT_WIDTH  = 24;
    localparam int          NUM_DMA      = 4;
    // Timer slots within the array
    localparam int          IDX_WAKE     = 0;
    localparam int          IDX_GP_FIRST = 1;
    localparam int          IDX_DMA_FIRST = 5;
    localparam int          IDX_CONV_ZERO = 9;
    localparam int          IDX_CONV_ONE  = 10;
    // Reset values
    localparam logic [23:0] COUNT_RESET  = 24'h000000;
    localparam logic        TRIG_RESET   = 1'b0;
    // Synchroniser depth ahead of any logic
    localparam int          SYNC_STAGES  = 2;
    // Counting source choice for the general and DMA timers
    typedef enum logic [0:0] {
        PTA_SRC_SYSTEM = 1'b0,
        PTA_SRC_OSC    = 1'b1
    } pta_src_t;
endpackage : pta_pkg

// ===== hdl/pta_timer.sv
// One periodic reloading down-counter
`timescale 1ns/1ps
module pta_timer #(
    parameter int WIDTH = pta_pkg::COUNT_WIDTH
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    pta_timer_if.tmr  bus
);
    logic [WIDTH-1:0] count_q;
    logic             expire_q;

    generate
        if (WIDTH < 2) begin : gBadWidth
            $error("pta_timer: WIDTH must be at least 2");
        end
    endgenerate

    // Count, hold when disabled, reload after zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= WIDTH'(pta_pkg::COUNT_RESET);
        end else if (bus.enable && bus.tick) begin
            if (count_q == '0) begin
                count_q <= bus.startValue;
            end else begin
                count_q <= count_q - WIDTH'(1);
            end
        end
    end

    // One-cycle trigger at the zero tick
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            expire_q <= pta_pkg::TRIG_RESET;
        end else begin
            expire_q <= bus.enable && bus.tick && bus.trigEnable && (count_q == '0);
        end
    end

    assign bus.count  = count_q;
    assign bus.expire = expire_q;
endmodule : pta_timer

// ===== hdl/pta_timer_if.sv
// Control and status bundle between the array top and one timer
`timescale 1ns/1ps
interface pta_timer_if #(parameter int WIDTH = pta_pkg::COUNT_WIDTH);
    logic [WIDTH-1:0] startValue;
    logic             enable;
    logic             trigEnable;
    logic             tick;
    logic [WIDTH-1:0] count;
    logic             expire;

    modport ctl (output startValue, output enable, output trigEnable, output tick,
                 input count, input expire);
    modport tmr (input startValue, input enable, input trigEnable, input tick,
                 output count, output expire);
endinterface : pta_timer_if

// ===== tb/periodic_timer_array_tb.sv
// Self-checking bench for the periodic timer array
`timescale 1ns/1ps
module periodic_timer_array_tb;
    logic mclk, reset_n, wakeClk, oscClk, srcSelect, wakeupTick, convTriggerZero, convTriggerOne;
    logic [10:0][23:0] startValue, countValue;
    logic [10:0] timerEnable, trigEnable, irqRequest;
    logic [3:0] dmaRequest;
    logic [5:0] seen;
    logic [31:0] seed;
    logic [23:0] held;
    int errCount, numChecks, n;
    periodic_timer_array uut (.mclk, .reset_n, .wakeClk, .oscClk, .srcSelect, .startValue, .timerEnable,
        .trigEnable, .countValue, .irqRequest, .dmaRequest, .wakeupTick, .convTriggerZero, .convTriggerOne);
    pta_consumer model (.mclk, .reset_n, .dmaRequest, .convTrig({convTriggerOne, convTriggerZero}), .seen);
    always #12.5 mclk = ~mclk;
    always #173 oscClk = ~oscClk;
    always #511 wakeClk = ~wakeClk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] expPeriod(input logic [23:0] sv);
        return 32'(sv) + 32'h1;
    endfunction : expPeriod
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", s, e, g);
            errCount++;
        end
    endtask : chk
    task automatic close_out;
        if (errCount == 0 && numChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic waitPulse(input int i, input int lim);
        n = 0;
        @(negedge mclk);
        while (irqRequest[i] !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (n >= lim) begin
            errCount++;
            close_out;
        end
    endtask : waitPulse
    initial begin
        {mclk, reset_n, wakeClk, oscClk, srcSelect} = '0;
        seed = 32'h48d8;
        timerEnable = '1;
        trigEnable = '1;
        for (int i = 0; i < 11; i++) begin
            seed = lfsr(seed);
            startValue[i] = 24'(seed[2:0]) + 24'h1;
        end
        startValue[10] = 24'h0;
        repeat (2) @(posedge mclk);
        #2 reset_n = 1'b1;
        for (int i = 1; i < 11; i++) begin
            waitPulse(i, 200);
            waitPulse(i, 200);
            chk("period", expPeriod(startValue[i]), n + 1);
        end
        chk("consumer", 32'h3f, 32'(seen));
        chk("count read", 32'h1, 32'(countValue[9] <= startValue[9]));
        waitPulse(0, 1000);
        startValue[10] = 24'h6;
        repeat (2) @(posedge mclk);
        @(posedge mclk);
        #2 timerEnable[10] = 1'b0;
        trigEnable[9] = 1'b0;
        held = countValue[10];
        @(negedge mclk);
        n = 0;
        repeat (19) begin
            @(negedge mclk);
            if (irqRequest[9] !== 1'b0) n++;
        end
        chk("held count", 32'(held), 32'(countValue[10]));
        chk("trig off", 32'h0, n);
        @(posedge mclk);
        #2 srcSelect = 1'b1;
        waitPulse(1, 300);
        waitPulse(1, 300);
        chk("osc period", 32'h1, 32'(n + 1 > 2 * expPeriod(startValue[1])));
        close_out;
    end
endmodule : periodic_timer_array_tb
bind periodic_timer_array pta_monitor #(.WIDTH(WIDTH)) mon (.*);

// ===== tb/pta_consumer.sv
// Consumer model: records which DMA and converter trigger lines fired
`timescale 1ns/1ps
module pta_consumer (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [3:0] dmaRequest,
    input  wire logic [1:0] convTrig,
    output logic      [5:0] seen
);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) seen <= '0;
        else seen <= seen | {convTrig, dmaRequest};
    end
endmodule : pta_consumer

// ===== tb/pta_monitor.sv
// Checker on the timer array ports
`timescale 1ns/1ps
module pta_monitor #(parameter int WIDTH = 24) (
    input wire logic mclk, reset_n, wakeClk, oscClk, srcSelect, wakeupTick, convTriggerZero, convTriggerOne,
    input wire logic [10:0][WIDTH-1:0] startValue, countValue,
    input wire logic [10:0] timerEnable, trigEnable, irqRequest,
    input wire logic [3:0] dmaRequest
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    dma_copy_a: assert property (dmaRequest == irqRequest[8:5]) else $error("dma copy");
    wake_copy_a: assert property (wakeupTick == irqRequest[0]) else $error("wake copy");
    conv_copy_a: assert property ({convTriggerOne, convTriggerZero} == irqRequest[10:9]) else $error("conv copy");
    conv_reload_a: assert property ($past(reset_n) && timerEnable[9] && countValue[9] == 0
        |=> countValue[9] == $past(startValue[9])) else $error("reload");
    conv_count_a: assert property (timerEnable[9] && countValue[9] != 0
        |=> countValue[9] == $past(countValue[9]) - 1'b1) else $error("decrement");
    conv_pulse_a: assert property ($past(reset_n) && timerEnable[9] && trigEnable[9] && countValue[9] == 0
        |=> irqRequest[9]) else $error("pulse");
    trig_off_a: assert property (!trigEnable[9] |=> !irqRequest[9]) else $error("trig off");
    hold_count_a: assert property (!timerEnable[10] |=> $stable(countValue[10])) else $error("hold");
    quiet_off_a: assert property (!timerEnable[10] |=> !irqRequest[10]) else $error("quiet");
endmodule : pta_monitor
